// file: hdl/vdr_pkg.sv
// constants shared by the vibration data readout block
package vdr_pkg;

    // register byte offsets, each register is a 16-bit word
    localparam logic [6:0] VDR_ADDR_SUPPLY  = 7'h0A;
    localparam logic [6:0] VDR_ADDR_TEMP    = 7'h0C;
    localparam logic [6:0] VDR_ADDR_PTR     = 7'h10;
    localparam logic [6:0] VDR_ADDR_RECIDX  = 7'h12;
    localparam logic [6:0] VDR_ADDR_XBUF    = 7'h14;
    localparam logic [6:0] VDR_ADDR_YBUF    = 7'h16;
    localparam logic [6:0] VDR_ADDR_ZBUF    = 7'h18;
    localparam logic [6:0] VDR_ADDR_CMD     = 7'h3E;
    localparam logic [6:0] VDR_ADDR_TIME_LO = 7'h4C;
    localparam logic [6:0] VDR_ADDR_TIME_HI = 7'h4E;
    localparam logic [6:0] VDR_ADDR_INFO    = 7'h76;

    // values after reset
    localparam logic [15:0] VDR_RST_SAMPLE  = 16'h8000;
    localparam logic [15:0] VDR_RST_MEAS    = 16'h8000;
    localparam logic [8:0]  VDR_RST_PTR     = 9'h000;
    localparam logic [3:0]  VDR_RST_RECIDX  = 4'h0;

    // field widths and command bit positions (within the high byte)
    localparam int VDR_PTR_W       = 9;
    localparam int VDR_RECIDX_W    = 4;
    localparam int VDR_MEAS_W      = 12;
    localparam int VDR_CMD_RESTORE = 5;   // word bit 13
    localparam int VDR_CMD_PTRCLR  = 2;   // word bit 10

    // record lengths per mode
    localparam logic [9:0] VDR_LEN_FFT  = 10'h100;
    localparam logic [9:0] VDR_LEN_TIME = 10'h200;

    // clock and timing
    localparam int VDR_CLK_NS        = 8;
    localparam int VDR_RESTORE_NS    = 1_900_000;
    localparam int VDR_RESTORE_CYC   = VDR_RESTORE_NS / VDR_CLK_NS;
    localparam int VDR_SUP_RATE_HZ   = 50_000;
    localparam int VDR_SUP_WIN_NS    = 5_120_000;
    localparam int VDR_SUP_PER_NS    = 1_000_000_000 / VDR_SUP_RATE_HZ;
    localparam int VDR_SUP_PER_CYC   = VDR_SUP_PER_NS / VDR_CLK_NS;
    localparam int VDR_SUP_COUNT     = VDR_SUP_WIN_NS / VDR_SUP_PER_NS;
    localparam int VDR_SUP_SHIFT     = 8;
    localparam int VDR_TMP_WIN_NS    = 1_700_000;
    localparam int VDR_TMP_COUNT     = 64;
    localparam int VDR_TMP_PER_CYC   = VDR_TMP_WIN_NS / VDR_TMP_COUNT / VDR_CLK_NS;
    localparam int VDR_TMP_SHIFT     = 6;

    // frame layout on the serial link
    localparam int VDR_FRAME_W = 16;

endpackage : vdr_pkg

// file: hdl/vdr_readout.sv
// vibration data readout: serial register access, sample windows, meas averaging
// Notes on behaviour
// - finished event loads sample zero, pointer cleared
// - nine-bit pointer selects presented sample position
// - window read advances pointer, reloads all three
// - sequential reads fetch whole record, no rewrite
// - time mode 512 samples, else 256 bins
// - record index plus restore command loads record
// - sample format follows recording mode, range setting
// - fft mode words are unsigned magnitudes
// - time mode words are two's complement
// - supply sampled 5.12 ms at 50 kHz
// - temperature sampled 64 times over 1.7 ms
// - supply and temperature averaged into registers
// - supply reading twelve bits, upper bits zero
// - temperature reading twelve-bit offset binary
// - command bits self-clear when function completes
// - retrieval refreshes time stamp, record header
`timescale 1ns/1ps
`default_nettype none
module vdr_readout
    import vdr_pkg::*;
#(
    parameter int RESTORE_CYC = VDR_RESTORE_CYC,   // restore timeout in cycles
    parameter int DEPTH       = 512                // sample positions per axis
) (
    // system clock, reset, enable
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    // serial link from host (mode 3)
    input  wire logic        spi_clk_in,
    input  wire logic        spi_cs_n_in,
    input  wire logic        spi_mosi_in,
    output logic             spi_miso_out,
    output logic             spi_miso_oe_out,
    // recording settings
    input  wire logic        time_mode_in,
    input  wire logic [1:0]  range_in,
    // sample buffer fill from processing or flash
    input  wire logic        buf_wr_en_in,
    input  wire logic [8:0]  buf_wr_idx_in,
    input  wire logic [15:0] buf_wr_x_in,
    input  wire logic [15:0] buf_wr_y_in,
    input  wire logic [15:0] buf_wr_z_in,
    // recording events and header
    input  wire logic        rec_start_in,
    input  wire logic        evt_done_in,
    input  wire logic [31:0] hdr_time_in,
    input  wire logic [15:0] hdr_info_in,
    // measurement converters
    input  wire logic [11:0] supply_code_in,
    input  wire logic [11:0] temp_code_in,
    // flash record retrieval
    output logic             rec_req_out,
    output logic [3:0]       rec_sel_out,
    input  wire logic        rec_done_in
);

    // ---------------- link domain ----------------
    logic [1:0]  lrst_sync_r;        // reset brought into link domain
    logic [3:0]  bit_cnt_r;          // bits received in current frame
    logic [15:0] rx_shift_r;         // incoming shift register
    logic [15:0] rx_frame_r;         // last full frame, held stable
    logic        rx_tgl_r;           // toggles once per full frame
    logic [15:0] tx_shift_r;         // outgoing shift register
    logic        miso_r;             // outgoing bit

    // reset synchroniser for the link clock
    always_ff @(posedge spi_clk_in) begin
        lrst_sync_r <= {lrst_sync_r[0], rstn_in};
    end

    // receive: sample mosi on rising edge, publish frame on sixteenth bit
    always_ff @(posedge spi_clk_in) begin
        if (!lrst_sync_r[1]) begin
            bit_cnt_r  <= 4'h0;
            rx_shift_r <= 16'h0000;
            rx_frame_r <= 16'h0000;
            rx_tgl_r   <= 1'b0;
        end else if (!spi_cs_n_in) begin
            rx_shift_r <= {rx_shift_r[14:0], spi_mosi_in};
            bit_cnt_r  <= bit_cnt_r + 4'h1;
            // frame complete
            if (bit_cnt_r == 4'hF) begin
                rx_frame_r <= {rx_shift_r[14:0], spi_mosi_in};
                rx_tgl_r   <= ~rx_tgl_r;
            end
        end
    end

    logic [15:0] tx_word_r;          // answer prepared by system domain

    // transmit: shift out on falling edge, word loaded at frame start
    always_ff @(negedge spi_clk_in) begin
        if (!lrst_sync_r[1]) begin
            tx_shift_r <= 16'h0000;
            miso_r     <= 1'b0;
        end else if (!spi_cs_n_in) begin
            if (bit_cnt_r == 4'h0) begin
                tx_shift_r <= tx_word_r;
                miso_r     <= tx_word_r[15];
            end else begin
                tx_shift_r <= {tx_shift_r[14:0], 1'b0};
                miso_r     <= tx_shift_r[14];
            end
        end
    end

    // ---------------- system domain ----------------
    logic [1:0]  tgl_sync_r;         // frame toggle synchroniser
    logic        tgl_seen_r;         // last toggle value acted on
    logic [1:0]  cs_sync_r;          // chip select synchroniser
    logic [8:0]  ptr_r;              // sample index pointer
    logic [8:0]  ptr_nxt;
    logic [3:0]  rec_idx_r;          // stored record index
    logic [15:0] x_win_r;            // x sample window
    logic [15:0] y_win_r;            // y sample window
    logic [15:0] z_win_r;            // z sample window
    logic [11:0] supply_r;           // averaged supply
    logic [11:0] temp_r;             // averaged temperature
    logic        supply_ld_r;        // supply holds a measured value
    logic        temp_ld_r;          // temperature holds a measured value
    logic [31:0] time_r;             // record time stamp
    logic [15:0] info_r;             // record settings header
    logic [19:0] rest_cnt_r;         // restore timeout counter
    logic        miso_oe_r;          // drive enable for miso

    // sample storage, one word per position and axis
    logic [15:0] mem_x [DEPTH];
    logic [15:0] mem_y [DEPTH];
    logic [15:0] mem_z [DEPTH];

    // frame decode
    wire         frame_new = (tgl_sync_r[1] != tgl_seen_r);
    wire         f_wr      = rx_frame_r[15];
    wire  [6:0]  f_addr    = rx_frame_r[14:8];
    wire  [7:0]  f_data    = rx_frame_r[7:0];
    wire  [6:0]  f_word    = {f_addr[6:1], 1'b0};
    wire         f_hi      = f_addr[0];
    wire         rd_evt    = ce_in && frame_new && !f_wr;
    wire         wr_evt    = ce_in && frame_new && f_wr;

    // window read detection
    wire         win_rd    = rd_evt && ((f_word == VDR_ADDR_XBUF) ||
                                        (f_word == VDR_ADDR_YBUF) ||
                                        (f_word == VDR_ADDR_ZBUF));
    wire         ptr_wr    = wr_evt && (f_word == VDR_ADDR_PTR);
    wire         idx_wr    = wr_evt && (f_word == VDR_ADDR_RECIDX) && !f_hi;
    wire         cmd_wr    = wr_evt && (f_word == VDR_ADDR_CMD) && f_hi;
    wire         restore_go = cmd_wr && f_data[VDR_CMD_RESTORE] && !rec_req_out;
    wire         ptr_clr   = cmd_wr && f_data[VDR_CMD_PTRCLR];
    wire         rest_tmo  = rec_req_out && (rest_cnt_r == 20'(RESTORE_CYC - 1));

    // record length depends on recording mode
    // mode record length
    wire  [9:0]  rec_len   = time_mode_in ? VDR_LEN_TIME : VDR_LEN_FFT;

    // pointer step with wrap at record end
    function automatic logic [8:0] vdr_step(input logic [8:0] p, input logic [9:0] len);
        logic [9:0] s;
        s = {1'b0, p} + 10'h001;
        vdr_step = (s >= len) ? 9'h000 : s[8:0];
    endfunction : vdr_step

    // next pointer value, priorities: event, clear, write, read
    always_comb begin
        ptr_nxt = ptr_r;
        if (evt_done_in || rec_done_in) begin
            ptr_nxt = VDR_RST_PTR;
        end else if (ptr_clr) begin
            ptr_nxt = VDR_RST_PTR;
        end else if (ptr_wr) begin
            ptr_nxt = f_hi ? {f_data[0], ptr_r[7:0]} : {ptr_r[8], f_data};
        end else if (win_rd) begin
            ptr_nxt = vdr_step(ptr_r, rec_len);
        end
    end

    wire         reload = evt_done_in || rec_done_in || ptr_clr || ptr_wr || win_rd;

    // link synchronisers
    always_ff @(posedge sys_clk_in) begin
        tgl_sync_r <= {tgl_sync_r[0], rx_tgl_r};
        cs_sync_r  <= {cs_sync_r[0], spi_cs_n_in};
    end

    // frame acknowledge and miso drive enable
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            tgl_seen_r <= 1'b0;
            miso_oe_r  <= 1'b0;
        end else if (ce_in) begin
            tgl_seen_r <= tgl_sync_r[1];
            miso_oe_r  <= ~cs_sync_r[1];
        end
    end

    // buffer fill from processing or flash
    always_ff @(posedge sys_clk_in) begin
        if (ce_in && buf_wr_en_in) begin
            mem_x[buf_wr_idx_in] <= buf_wr_x_in;
            mem_y[buf_wr_idx_in] <= buf_wr_y_in;
            mem_z[buf_wr_idx_in] <= buf_wr_z_in;
        end
    end

    // pointer and windows
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            ptr_r   <= VDR_RST_PTR;
            x_win_r <= VDR_RST_SAMPLE;
            y_win_r <= VDR_RST_SAMPLE;
            z_win_r <= VDR_RST_SAMPLE;
        end else if (ce_in) begin
            ptr_r <= ptr_nxt;
            if (reload) begin
                x_win_r <= mem_x[ptr_nxt];
                y_win_r <= mem_y[ptr_nxt];
                z_win_r <= mem_z[ptr_nxt];
            end
        end
    end

    // record index register
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rec_idx_r <= VDR_RST_RECIDX;
        end else if (ce_in && idx_wr) begin
            rec_idx_r <= f_data[3:0];
        end
    end

    // restore command: request flash copy, bit self-clears on done or timeout
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rec_req_out <= 1'b0;
            rec_sel_out <= VDR_RST_RECIDX;
            rest_cnt_r  <= 20'h00000;
        end else if (ce_in) begin
            if (restore_go) begin
                rec_req_out <= 1'b1;
                rec_sel_out <= rec_idx_r;
                rest_cnt_r  <= 20'h00000;
            end else if (rec_done_in || rest_tmo) begin
                rec_req_out <= 1'b0;
            end else if (rec_req_out) begin
                rest_cnt_r  <= rest_cnt_r + 20'h00001;
            end
        end
    end

    // header registers
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            time_r <= 32'h0000_0000;
            info_r <= 16'h0000;
        end else if (ce_in && (evt_done_in || rec_done_in)) begin
            time_r <= hdr_time_in;
            info_r <= hdr_info_in;
        end
    end

    // ---------------- supply and temperature averaging ----------------
    logic        meas_on_r;          // sampling window active
    logic [11:0] sup_tick_r;         // supply sample period counter
    logic [11:0] tmp_tick_r;         // temperature sample period counter
    logic [8:0]  sup_n_r;            // supply samples taken
    logic [6:0]  tmp_n_r;            // temperature samples taken
    logic [19:0] sup_acc_r;          // supply sum
    logic [17:0] tmp_acc_r;          // temperature sum

    wire sup_take = meas_on_r && (sup_tick_r == 12'(VDR_SUP_PER_CYC - 1)) &&
                    (sup_n_r != 9'(VDR_SUP_COUNT));
    wire tmp_take = meas_on_r && (tmp_tick_r == 12'(VDR_TMP_PER_CYC - 1)) &&
                    (tmp_n_r != 7'(VDR_TMP_COUNT));
    wire sup_full = (sup_n_r == 9'(VDR_SUP_COUNT));
    wire tmp_full = (tmp_n_r == 7'(VDR_TMP_COUNT));

    // sample counters and accumulators
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            meas_on_r  <= 1'b0;
            sup_tick_r <= 12'h000;
            tmp_tick_r <= 12'h000;
            sup_n_r    <= 9'h000;
            tmp_n_r    <= 7'h00;
            sup_acc_r  <= 20'h00000;
            tmp_acc_r  <= 18'h00000;
        end else if (ce_in) begin
            if (rec_start_in) begin
                // new recording restarts both series
                meas_on_r  <= 1'b1;
                sup_tick_r <= 12'h000;
                tmp_tick_r <= 12'h000;
                sup_n_r    <= 9'h000;
                tmp_n_r    <= 7'h00;
                sup_acc_r  <= 20'h00000;
                tmp_acc_r  <= 18'h00000;
            end else if (meas_on_r) begin
                sup_tick_r <= sup_take ? 12'h000 : sup_tick_r + 12'h001;
                tmp_tick_r <= tmp_take ? 12'h000 : tmp_tick_r + 12'h001;
                if (sup_take) begin
                    sup_n_r   <= sup_n_r + 9'h001;
                    sup_acc_r <= sup_acc_r + {8'h00, supply_code_in};
                end
                if (tmp_take) begin
                    tmp_n_r   <= tmp_n_r + 7'h01;
                    tmp_acc_r <= tmp_acc_r + {6'h00, temp_code_in};
                end
                if (sup_full && tmp_full) begin
                    meas_on_r <= 1'b0;
                end
            end
        end
    end

    // averages written once each series is complete
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            supply_r    <= 12'h000;
            temp_r      <= 12'h000;
            supply_ld_r <= 1'b0;
            temp_ld_r   <= 1'b0;
        end else if (ce_in && meas_on_r && !rec_start_in) begin
            if (sup_full && !supply_ld_r) begin
                supply_r    <= sup_acc_r[19:8];
                supply_ld_r <= 1'b1;
            end
            if (tmp_full && !temp_ld_r) begin
                temp_r    <= tmp_acc_r[17:6];
                temp_ld_r <= 1'b1;
            end
        end else if (ce_in && rec_start_in) begin
            supply_ld_r <= 1'b0;
            temp_ld_r   <= 1'b0;
        end
    end

    // readings: default pattern until the first average after reset or after each recording start
    // supply twelve bits
    wire [15:0] supply_rd = supply_ld_r ? {4'h0, supply_r} : VDR_RST_MEAS;
    wire [15:0] temp_rd   = temp_ld_r ? {4'h0, temp_r} : VDR_RST_MEAS;

    // ---------------- read answers ----------------
    logic [15:0] rd_word;

    // register read selection
    always_comb begin
        unique case (f_word)
            VDR_ADDR_SUPPLY:  rd_word = supply_rd;
            VDR_ADDR_TEMP:    rd_word = temp_rd;
            VDR_ADDR_PTR:     rd_word = {7'h00, ptr_r};
            VDR_ADDR_RECIDX:  rd_word = {12'h000, rec_idx_r};
            VDR_ADDR_XBUF:    rd_word = x_win_r;
            VDR_ADDR_YBUF:    rd_word = y_win_r;
            VDR_ADDR_ZBUF:    rd_word = z_win_r;
            VDR_ADDR_CMD:     rd_word = {2'b00, rec_req_out, 13'h0000};
            VDR_ADDR_TIME_LO: rd_word = time_r[15:0];
            VDR_ADDR_TIME_HI: rd_word = time_r[31:16];
            VDR_ADDR_INFO:    rd_word = info_r;
            default:          rd_word = 16'h0000;
        endcase
    end

    // answer word for the next frame, captured before pointer moves
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            tx_word_r <= 16'h0000;
        end else if (rd_evt) begin
            tx_word_r <= rd_word;
        end
    end

    // outputs
    assign spi_miso_out    = miso_r;
    assign spi_miso_oe_out = miso_oe_r;

    // range setting travels with the stored words, no conversion here
    wire unused_ok = &{1'b0, range_in};

endmodule : vdr_readout
`default_nettype wire

// file: tb/vdr_readout_chk.sv
// checker watching the readout block's link enable and restore outputs
`timescale 1ns/1ps
`default_nettype none
module vdr_readout_chk #(
    parameter int RESTORE_CYC = 2000    // restore timeout in cycles
) (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    // link pins
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_miso_out,
    input  wire logic       spi_miso_oe_out,
    // restore handshake
    input  wire logic       rec_req_out,
    input  wire logic [3:0] rec_sel_out,
    input  wire logic       rec_done_in
);
    int          busy_cnt_r;   // cycles with a restore pending
    logic [3:0]  done_hist_r;  // last four samples of the flash done pulse
    // count restore cycles and keep a short history of done pulses
    always_ff @(posedge sys_clk_in) begin
        busy_cnt_r <= (!rstn_in || !rec_req_out) ? 0 : busy_cnt_r + 1;
        done_hist_r <= {done_hist_r[2:0], rec_done_in};
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // frame selected or deselected long enough for the enable to follow
    sequence link_busy; !spi_cs_n_in [*6]; endsequence
    sequence link_idle; spi_cs_n_in [*6]; endsequence
    reset_outputs_a: assert property (disable iff (1'b0) !rstn_in [*6] |=>
        !spi_miso_out && !spi_miso_oe_out && !rec_req_out && rec_sel_out == 4'h0)
        else $error("outputs not at reset level");
    enable_follows_a: assert property (link_busy |-> spi_miso_oe_out)
        else $error("miso enable missing in frame");
    enable_release_a: assert property (link_idle |-> !spi_miso_oe_out)
        else $error("miso enable held outside frame");
    done_clears_a: assert property (rec_req_out && rec_done_in |-> ##[1:5] !rec_req_out)
        else $error("restore flag not cleared by done");
    busy_bound_a: assert property (busy_cnt_r <= RESTORE_CYC + 8)
        else $error("restore flag stuck");
    select_stable_a: assert property (rec_req_out ##1 rec_req_out |-> $stable(rec_sel_out))
        else $error("record select changed during restore");
    request_cause_a: assert property ($rose(rec_req_out) |-> !$past(spi_cs_n_in, 10))
        else $error("restore started without a frame");
    fall_cause_a: assert property ($fell(rec_req_out) |->
        (|done_hist_r) || $past(busy_cnt_r) >= RESTORE_CYC - 2)
        else $error("restore flag dropped without cause");
endmodule : vdr_readout_chk
bind vdr_readout vdr_readout_chk #(.RESTORE_CYC(RESTORE_CYC)) vdr_readout_chk_i (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .spi_cs_n_in(spi_cs_n_in),
    .spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out),
    .rec_req_out(rec_req_out), .rec_sel_out(rec_sel_out), .rec_done_in(rec_done_in));
`default_nettype wire

// file: tb/vdr_host_model.sv
// host model: link master sending sixteen-bit frames, clock idle high
`timescale 1ns/1ps
`default_nettype none
module vdr_host_model (
    // link pins
    output logic      spi_clk_out,
    output logic      spi_cs_n_out,
    output logic      spi_mosi_out,
    input  wire logic spi_miso_in,
    input  wire logic spi_miso_oe_in
);
    // undriven miso shows the inverse of the last level, never a kind value
    wire line_w = spi_miso_oe_in ? spi_miso_in : ~spi_miso_in;
    // idle levels from time zero
    initial begin
        spi_clk_out = 1'b1;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end
    // clock bursts with no frame, only while the link reset settles
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #7.5 spi_clk_out = 1'b0;
            #7.5 spi_clk_out = 1'b1;
        end
    endtask : idle_clocks
    // one whole frame, msb first; data set on falling, taken on rising
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        spi_cs_n_out = 1'b0;
        // lead time so miso is driven by the first edge
        #40;
        for (int i = 15; i >= 0; i--) begin
            #7.5 spi_clk_out = 1'b0;
            spi_mosi_out = tx[i];
            #7.5 spi_clk_out = 1'b1;
            rx[i] = line_w;
        end
        #7.5 spi_cs_n_out = 1'b1;
        spi_mosi_out = ~spi_mosi_out;
        // gap so the answer is ready before the next frame
        #100;
    endtask : xfer
endmodule : vdr_host_model
`default_nettype wire

// file: tb/vdr_readout_bench.sv
// testbench for the vibration data readout block
`timescale 1ns/1ps
`default_nettype none
module vdr_readout_bench;
    import vdr_pkg::*;
    localparam int RCYC = 2000;   // shortened restore timeout
    // design inputs and outputs
    logic sys_clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1, time_mode_in = 1'b0;
    logic spi_clk_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, spi_miso_oe_out;
    logic [1:0]  range_in = 2'h1;
    logic        buf_wr_en_in = 1'b0, rec_start_in = 1'b0, evt_done_in = 1'b0;
    logic [8:0]  buf_wr_idx_in = 9'h000;
    logic [15:0] buf_wr_x_in = 16'h0000, buf_wr_y_in = 16'h0000, buf_wr_z_in = 16'h0000;
    logic [31:0] hdr_time_in = 32'h0;
    logic [15:0] hdr_info_in = 16'h0000;
    logic [11:0] supply_code_in = 12'hA8F, temp_code_in = 12'h4FE;
    logic        rec_req_out, rec_done_in = 1'b0;
    logic [3:0]  rec_sel_out;
    int          err_count = 0;
    int          comparisons = 0;
    vdr_readout #(.RESTORE_CYC(RCYC), .DEPTH(512)) vdr_readout_i (
        .sys_clk_in, .rstn_in, .ce_in, .spi_clk_in, .spi_cs_n_in, .spi_mosi_in,
        .spi_miso_out, .spi_miso_oe_out, .time_mode_in, .range_in, .buf_wr_en_in,
        .buf_wr_idx_in, .buf_wr_x_in, .buf_wr_y_in, .buf_wr_z_in, .rec_start_in,
        .evt_done_in, .hdr_time_in, .hdr_info_in, .supply_code_in, .temp_code_in,
        .rec_req_out, .rec_sel_out, .rec_done_in);
    vdr_host_model vdr_host_model_i (
        .spi_clk_out(spi_clk_in), .spi_cs_n_out(spi_cs_n_in), .spi_mosi_out(spi_mosi_in),
        .spi_miso_in(spi_miso_out), .spi_miso_oe_in(spi_miso_oe_out));
    // system clock
    initial begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    // compare one value and count it
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // register write frame
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] v;
        vdr_host_model_i.xfer({1'b1, a, d}, v);
    endtask : wr
    // register read: request frame, then a frame to an unmapped place carries the answer
    task automatic rd_chk(input string s, input logic [6:0] a, input logic [15:0] e);
        logic [15:0] v;
        vdr_host_model_i.xfer({1'b0, a, 8'h00}, v);
        vdr_host_model_i.xfer(16'h0000, v);
        chk(s, v, e);
    endtask : rd_chk
    // sample pattern: fill tag, axis, position
    function automatic logic [15:0] pat(input logic [3:0] t, input logic [2:0] ax, input int i);
        return {t, ax, i[8:0]};
    endfunction : pat
    // write all 512 positions of the three axis buffers
    task automatic fill(input logic [3:0] t);
        for (int i = 0; i < 512; i++) begin
            @(posedge sys_clk_in);
            buf_wr_en_in <= 1'b1;
            buf_wr_idx_in <= i[8:0];
            buf_wr_x_in <= pat(t, 3'h0, i);
            buf_wr_y_in <= pat(t, 3'h1, i);
            buf_wr_z_in <= pat(t, 3'h2, i);
        end
        @(posedge sys_clk_in);
        buf_wr_en_in <= 1'b0;
    endtask : fill
    // print counts and verdict, then stop
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge sys_clk_in);
        err_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        fork
            vdr_host_model_i.idle_clocks(6);
            repeat (8) @(posedge sys_clk_in);
        join
        @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        vdr_host_model_i.idle_clocks(3);
        repeat (4) @(posedge sys_clk_in);
        wr(VDR_ADDR_SUPPLY, 8'h12);
        rd_chk("supply", VDR_ADDR_SUPPLY, VDR_RST_MEAS);
        rd_chk("temperature", VDR_ADDR_TEMP, VDR_RST_MEAS);
        rd_chk("pointer", VDR_ADDR_PTR, 16'h0000);
        rd_chk("record index", VDR_ADDR_RECIDX, 16'h0000);
        rd_chk("unmapped", 7'h20, 16'h0000);
        rd_chk("x reset", VDR_ADDR_XBUF, VDR_RST_SAMPLE);
        $display("reset values done");
        fill(4'h3);
        @(posedge sys_clk_in);
        evt_done_in <= 1'b1;
        @(posedge sys_clk_in);
        evt_done_in <= 1'b0;
        rd_chk("x first", VDR_ADDR_XBUF, pat(4'h3, 3'h0, 0));
        rd_chk("y next", VDR_ADDR_YBUF, pat(4'h3, 3'h1, 1));
        rd_chk("pointer", VDR_ADDR_PTR, 16'h0002);
        for (int i = 2; i < 256; i++) begin
            rd_chk("z run", VDR_ADDR_ZBUF, pat(4'h3, 3'h2, i));
        end
        rd_chk("x wrap", VDR_ADDR_XBUF, pat(4'h3, 3'h0, 0));
        $display("sequential read done");
        // high byte first, then low byte
        wr(VDR_ADDR_PTR + 7'h01, 8'h00);
        wr(VDR_ADDR_PTR, 8'h9F);
        rd_chk("x at 9F", VDR_ADDR_XBUF, pat(4'h3, 3'h0, 'h9F));
        rd_chk("y at A0", VDR_ADDR_YBUF, pat(4'h3, 3'h1, 'hA0));
        @(posedge sys_clk_in);
        time_mode_in <= 1'b1;
        wr(VDR_ADDR_PTR + 7'h01, 8'hFF);
        wr(VDR_ADDR_PTR, 8'hFF);
        rd_chk("pointer", VDR_ADDR_PTR, 16'h01FF);
        rd_chk("x at 1FF", VDR_ADDR_XBUF, pat(4'h3, 3'h0, 'h1FF));
        rd_chk("pointer wrap", VDR_ADDR_PTR, 16'h0000);
        rd_chk("y at 0", VDR_ADDR_YBUF, pat(4'h3, 3'h1, 0));
        wr(VDR_ADDR_CMD + 7'h01, 8'h04);
        rd_chk("pointer clear", VDR_ADDR_PTR, 16'h0000);
        rd_chk("command idle", VDR_ADDR_CMD, 16'h0000);
        rd_chk("x reload", VDR_ADDR_XBUF, pat(4'h3, 3'h0, 0));
        $display("pointer control done");
        wr(VDR_ADDR_RECIDX, 8'h0A);
        rd_chk("record index", VDR_ADDR_RECIDX, 16'h000A);
        wr(VDR_ADDR_CMD + 7'h01, 8'h20);
        chk("restore busy", {15'h0, rec_req_out}, 16'h0001);
        chk("restore select", {12'h0, rec_sel_out}, 16'h000A);
        rd_chk("command busy", VDR_ADDR_CMD, 16'h2000);
        fill(4'h5);
        @(posedge sys_clk_in);
        hdr_time_in <= 32'h0012_3456;
        hdr_info_in <= 16'h4C21;
        rec_done_in <= 1'b1;
        @(posedge sys_clk_in);
        rec_done_in <= 1'b0;
        rd_chk("time low", VDR_ADDR_TIME_LO, 16'h3456);
        rd_chk("time high", VDR_ADDR_TIME_HI, 16'h0012);
        rd_chk("record info", VDR_ADDR_INFO, 16'h4C21);
        rd_chk("command done", VDR_ADDR_CMD, 16'h0000);
        rd_chk("x record", VDR_ADDR_XBUF, pat(4'h5, 3'h0, 0));
        wr(VDR_ADDR_CMD + 7'h01, 8'h20);
        repeat (RCYC + 20) @(posedge sys_clk_in);
        #1 chk("restore timeout", {15'h0, rec_req_out}, 16'h0000);
        $display("record restore done");
        @(posedge sys_clk_in);
        rec_start_in <= 1'b1;
        @(posedge sys_clk_in);
        rec_start_in <= 1'b0;
        rd_chk("supply pending", VDR_ADDR_SUPPLY, VDR_RST_MEAS);
        $display("measurement start done");
        give_verdict();
    end
endmodule : vdr_readout_bench
`default_nettype wire
